// >>> acs_chk.sv
`timescale 1ns/100ps
module acs_chk (
  input wire clk,
  input wire srst,
  input wire [7:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWr,
  input wire regRd,
  input wire [31:0] regRdata,
  input wire [6:0] stage3GainNum,
  input wire [6:0] stage3OffsetNum,
  input wire fsTick,
  input wire quantStrobe,
  input wire busy,
  input wire convDone
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Free-running setting as last written
  reg contQ = 1'b0;
  always @(posedge clk)
  begin
    if (srst)
      contQ <= 1'b0;
    else if (regWr && regAddr == 8'h00)
      contQ <= regWdata[2] && !regWdata[1];
  end
  a_done_pulse: assert property (convDone |=> !convDone)
    else $error("done pulse too long");
  a_done_busy: assert property (convDone |-> $past(busy) && (!busy || $past(contQ)))
    else $error("busy not dropped with done");
  a_done_rerun: assert property (convDone && $past(contQ) |-> busy)
    else $error("free running did not restart");
  a_quant_done: assert property (quantStrobe |-> convDone)
    else $error("quantization strobe without done");
  a_rd_idle: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside read slot");
  a_rd_busy: assert property ($past(regRd) && $past(regAddr) == 8'h0C |-> regRdata == {31'h0, $past(busy)})
    else $error("status busy mismatch");
  a_tick_pulse: assert property (fsTick |=> !fsTick)
    else $error("tick too long");
  a_tick_busy: assert property (fsTick |-> $past(busy))
    else $error("tick while idle");
  a_restore_busy: assert property (regWr && regAddr == 8'h00 && regWdata[1] |=> busy)
    else $error("restore did not start");
  a_gain_copy: assert property (regWr && regAddr == 8'h08 |-> ##2 stage3GainNum == $past(regWdata[6:0], 2))
    else $error("gain code not applied");
  a_ofs_zero: assert property (regWr && regAddr == 8'h08 && regWdata[13:8] == 6'h00 |-> ##2 stage3OffsetNum == 7'h00)
    else $error("zero offset code not zero");
endmodule
bind acs_conv_seq acs_chk u_acs_chk (.clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .stage3GainNum(stage3GainNum),
  .stage3OffsetNum(stage3OffsetNum), .fsTick(fsTick), .quantStrobe(quantStrobe), .busy(busy), .convDone(convDone));

// >>> acs_conv_seq.v
`timescale 1ns/100ps
`include "acs_map.vh"

module acs_conv_seq #(
  parameter integer CLK_HZ = 40000000
)(
  input wire clk,
  input wire srst,
  input wire [7:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [31:0] regRdata,
  input wire modBit,
  output reg [6:0] stage3GainNum,
  output reg [6:0] stage3OffsetNum,
  output reg fsTick,
  output reg modReset,
  output reg chopPolarity,
  output reg bandgapState,
  output reg quantStrobe,
  output reg busy,
  output reg convDone,
  output reg irq
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_SETUP = 3'h1;
  localparam [2:0] ST_ELEM = 3'h2;
  localparam [2:0] ST_CLOSE = 3'h3;
  localparam [2:0] ST_QUANT = 3'h4;
  localparam integer SCALE_BASE = `ACS_RESULT_MSB_LOG2 - `ACS_OSR_BASE_LOG2;

  // Settings
  reg [1:0] sampleRateSelect_q;
  reg [2:0] oversampleRatioSelect_q;
  reg [1:0] elementaryCountSelect_q;
  reg [6:0] stage3GainCode_q;
  reg [6:0] stage3OffsetCode_q;
  reg [1:0] bgMode_q;
  reg contMode_q;
  reg [15:0] result_q;
  reg [`ACS_IRQ_W-1:0] irqStat_q;
  reg [`ACS_IRQ_W-1:0] irqMask_q;

  // Sequencer
  reg [2:0] state_q;
  reg [3:0] cycCnt_q;
  reg [10:0] periodCnt_q;
  reg [3:0] elemCnt_q;
  reg signed [15:0] acc_q;
  reg modSync1_q;
  reg modSync2_q;
  reg divRestart_q;
  wire tick;

  // Decoded bus operations
  wire wrCtrl = regWr && (regAddr == `ACS_REG_CTRL);
  wire wrCfg = regWr && (regAddr == `ACS_REG_CFG);
  wire wrStage3 = regWr && (regAddr == `ACS_REG_STAGE3);
  wire wrIrqStat = regWr && (regAddr == `ACS_REG_IRQ_STAT);
  wire wrIrqMask = regWr && (regAddr == `ACS_REG_IRQ_MASK);
  wire startReq = wrCtrl && regWdata[`ACS_CTRL_START];
  wire defReq = wrCtrl && regWdata[`ACS_CTRL_DEFAULTS];
  wire running = (state_q != ST_IDLE);

  // Elementary count and ratio as counts
  wire [10:0] osrValue = 11'h001 << (`ACS_OSR_BASE_LOG2 + oversampleRatioSelect_q);
  wire [3:0] nelValue = 4'h1 << elementaryCountSelect_q;

  // Mean of elementary results, scaled to a 16-bit code
  wire signed [15:0] meanVal = acc_q >>> elementaryCountSelect_q;
  wire [3:0] scaleShift = SCALE_BASE[3:0] - {1'b0, oversampleRatioSelect_q};
  wire signed [27:0] scaled = {{12{meanVal[15]}}, meanVal} <<< scaleShift;
  wire [15:0] satResult = (scaled > 28'sh0007FFF) ? 16'h7FFF :
                          (scaled < -28'sh0008000) ? 16'h8000 : scaled[15:0];

  function [6:0] offsetTwos;
    input [6:0] code;
    reg [6:0] mag;
    begin
      mag = {1'b0, code[5:0]};
      offsetTwos = code[6] ? (7'h00 - mag) : mag;
    end
  endfunction

  function isSel;
    input [7:0] a;
    input [7:0] off;
    begin
      isSel = (a == off);
    end
  endfunction

  acs_fs_div #(
    .CLK_HZ(CLK_HZ)
  ) u_div (
    .clk(clk),
    .srst(srst),
    .restart(divRestart_q),
    .rateSel(sampleRateSelect_q),
    .tick(tick)
  );

  // Modulator bit crosses in from the analog side
  always @(posedge clk)
  begin
    if (srst)
    begin
      modSync1_q <= 1'b0;
      modSync2_q <= 1'b0;
    end
    else
    begin
      modSync1_q <= modBit;
      modSync2_q <= modSync1_q;
    end
  end

  // Settings registers
  always @(posedge clk)
  begin
    if (srst || defReq)
    begin
      sampleRateSelect_q <= `ACS_DEF_FS;
      oversampleRatioSelect_q <= `ACS_DEF_OSR;
      elementaryCountSelect_q <= `ACS_DEF_NEL;
      stage3GainCode_q <= `ACS_DEF_GAIN;
      stage3OffsetCode_q <= `ACS_DEF_OFS;
      bgMode_q <= `ACS_DEF_BG;
      contMode_q <= 1'b0;
      irqMask_q <= {`ACS_IRQ_W{1'b0}};
    end
    else
    begin
      if (wrCtrl)
      begin
        contMode_q <= regWdata[`ACS_CTRL_CONT];
        bgMode_q <= regWdata[`ACS_CTRL_BG_HI:`ACS_CTRL_BG_LO];
      end
      if (wrCfg)
      begin
        sampleRateSelect_q <= regWdata[`ACS_CFG_FS_HI:`ACS_CFG_FS_LO];
        oversampleRatioSelect_q <= regWdata[`ACS_CFG_OSR_HI:`ACS_CFG_OSR_LO];
        elementaryCountSelect_q <= regWdata[`ACS_CFG_NEL_HI:`ACS_CFG_NEL_LO];
      end
      if (wrStage3)
      begin
        stage3GainCode_q <= regWdata[`ACS_S3_GAIN_HI:`ACS_S3_GAIN_LO];
        stage3OffsetCode_q <= regWdata[`ACS_S3_OFS_HI:`ACS_S3_OFS_LO];
      end
      if (wrIrqMask)
      begin
        irqMask_q <= regWdata[`ACS_IRQ_W-1:0];
      end
    end
  end

  // Analog third stage codes
  always @(posedge clk)
  begin
    if (srst)
    begin
      stage3GainNum <= 7'h00;
      stage3OffsetNum <= 7'h00;
    end
    else
    begin
      stage3GainNum <= stage3GainCode_q;
      stage3OffsetNum <= offsetTwos(stage3OffsetCode_q);
    end
  end

  // Conversion sequencer
  always @(posedge clk)
  begin
    if (srst)
    begin
      state_q <= ST_IDLE;
      cycCnt_q <= 4'h0;
      periodCnt_q <= 11'h000;
      elemCnt_q <= 4'h0;
      acc_q <= 16'sh0000;
      divRestart_q <= 1'b0;
      modReset <= 1'b1;
      chopPolarity <= 1'b0;
      bandgapState <= 1'b1;
      quantStrobe <= 1'b0;
      busy <= 1'b0;
      convDone <= 1'b0;
      result_q <= 16'h0000;
      fsTick <= 1'b0;
    end
    else
    begin
      convDone <= 1'b0;
      quantStrobe <= 1'b0;
      divRestart_q <= 1'b0;
      fsTick <= tick && (state_q == ST_ELEM || state_q == ST_QUANT);
      if (defReq || (startReq && !running))
      begin
        state_q <= ST_SETUP;
        cycCnt_q <= `ACS_SETUP_CYC;
        periodCnt_q <= 11'h000;
        elemCnt_q <= 4'h0;
        acc_q <= 16'sh0000;
        modReset <= 1'b1;
        chopPolarity <= 1'b0;
        busy <= 1'b1;
        divRestart_q <= 1'b1;
        // Mode being written in this same cycle sets the starting level
        bandgapState <= (defReq ? `ACS_DEF_BG : regWdata[`ACS_CTRL_BG_HI:`ACS_CTRL_BG_LO]) != `ACS_BG_LOW;
      end
      else
      begin
        case (state_q)
          ST_IDLE:
          begin
            busy <= 1'b0;
            modReset <= 1'b1;
          end
          ST_SETUP:
          begin
            if (cycCnt_q == 4'h0)
            begin
              state_q <= ST_ELEM;
              divRestart_q <= 1'b1;
            end
            else
            begin
              cycCnt_q <= cycCnt_q - 4'h1;
            end
          end
          ST_ELEM:
          begin
            if (tick)
            begin
              modReset <= 1'b0;
              if (periodCnt_q != 11'h000)
              begin
                acc_q <= (modSync2_q ^ chopPolarity) ? acc_q + 16'sh0001 : acc_q - 16'sh0001;
              end
              if (periodCnt_q == osrValue)
              begin
                periodCnt_q <= 11'h000;
                modReset <= 1'b1;
                chopPolarity <= ~chopPolarity;
                case (bgMode_q)
                  `ACS_BG_HIGH: bandgapState <= 1'b1;
                  `ACS_BG_LOW: bandgapState <= 1'b0;
                  `ACS_BG_TOG1: bandgapState <= ~bandgapState;
                  default: bandgapState <= elemCnt_q[0] ? ~bandgapState : bandgapState;
                endcase
                if (elemCnt_q == nelValue - 4'h1)
                begin
                  state_q <= ST_CLOSE;
                  cycCnt_q <= `ACS_CLOSE_CYC;
                end
                else
                begin
                  elemCnt_q <= elemCnt_q + 4'h1;
                end
              end
              else
              begin
                periodCnt_q <= periodCnt_q + 11'h001;
              end
            end
          end
          ST_CLOSE:
          begin
            if (cycCnt_q == 4'h0)
            begin
              state_q <= ST_QUANT;
              divRestart_q <= 1'b1;
            end
            else
            begin
              cycCnt_q <= cycCnt_q - 4'h1;
            end
          end
          ST_QUANT:
          begin
            if (tick)
            begin
              quantStrobe <= 1'b1;
              result_q <= satResult;
              convDone <= 1'b1;
              if (contMode_q)
              begin
                state_q <= ST_SETUP;
                cycCnt_q <= `ACS_SETUP_CYC;
                elemCnt_q <= 4'h0;
                acc_q <= 16'sh0000;
                chopPolarity <= 1'b0;
                divRestart_q <= 1'b1;
              end
              else
              begin
                state_q <= ST_IDLE;
                busy <= 1'b0;
              end
            end
          end
          default:
          begin
            state_q <= ST_IDLE;
            busy <= 1'b0;
          end
        endcase
      end
    end
  end

  // Sticky events; a new event wins over a clear
  always @(posedge clk)
  begin
    if (srst)
    begin
      irqStat_q <= {`ACS_IRQ_W{1'b0}};
      irq <= 1'b0;
    end
    else
    begin
      irqStat_q <= (irqStat_q & ~(wrIrqStat ? regWdata[`ACS_IRQ_W-1:0] : {`ACS_IRQ_W{1'b0}}))
                   | {startReq && !defReq && running, state_q == ST_QUANT && tick};
      irq <= |(irqStat_q & irqMask_q);
    end
  end

  // Read data, one cycle after the strobe
  always @(posedge clk)
  begin
    if (srst || !regRd)
    begin
      regRdata <= 32'h00000000;
    end
    else if (isSel(regAddr, `ACS_REG_CTRL))
    begin
      regRdata <= {27'h0000000, bgMode_q, contMode_q, 2'h0};
    end
    else if (isSel(regAddr, `ACS_REG_CFG))
    begin
      regRdata <= {25'h0000000, elementaryCountSelect_q, oversampleRatioSelect_q, sampleRateSelect_q};
    end
    else if (isSel(regAddr, `ACS_REG_STAGE3))
    begin
      regRdata <= {17'h00000, stage3OffsetCode_q, 1'b0, stage3GainCode_q};
    end
    else if (isSel(regAddr, `ACS_REG_STATUS))
    begin
      regRdata <= {31'h00000000, busy};
    end
    else if (isSel(regAddr, `ACS_REG_RESULT))
    begin
      regRdata <= {16'h0000, result_q};
    end
    else if (isSel(regAddr, `ACS_REG_IRQ_STAT))
    begin
      regRdata <= {30'h00000000, irqStat_q};
    end
    else if (isSel(regAddr, `ACS_REG_IRQ_MASK))
    begin
      regRdata <= {30'h00000000, irqMask_q};
    end
    else
    begin
      regRdata <= 32'h00000000;
    end
  end

endmodule

// >>> acs_conv_seq_tb.sv
`timescale 1ns/100ps
module acs_conv_seq_tb;
  localparam integer HZ = 4000000;
  localparam [34:0] GC = {7'h00, 7'h01, 7'h0C, 7'h40, 7'h7F};
  localparam [34:0] OC = {7'h00, 7'h3F, 7'h40, 7'h41, 7'h7F};
  localparam [34:0] OE = {7'h00, 7'h3F, 7'h00, 7'h7F, 7'h41};
  reg clk = 1'b0;
  reg srst = 1'b1;
  reg [7:0] regAddr = 8'h00;
  reg [31:0] regWdata = 32'h0;
  reg regWr = 1'b0;
  reg regRd = 1'b0;
  reg level = 1'b1;
  reg chopQ = 1'b0;
  reg bgQ = 1'b1;
  reg [31:0] d;
  wire [31:0] regRdata;
  wire [6:0] stage3GainNum;
  wire [6:0] stage3OffsetNum;
  wire modBit, fsTick, modReset, chopPolarity, bandgapState, quantStrobe, busy, convDone, irq;
  integer n_errors = 0, compares = 0, cyc = 0, nTick = 0, nChop = 0, nBg = 0, busyCyc = 0;
  integer tickGap = 0, lastTick = 0, i, t;
  integer tg [0:3];
  acs_conv_seq #(.CLK_HZ(HZ)) u_acs_conv_seq (.clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .modBit(modBit), .stage3GainNum(stage3GainNum),
    .stage3OffsetNum(stage3OffsetNum), .fsTick(fsTick), .modReset(modReset), .chopPolarity(chopPolarity),
    .bandgapState(bandgapState), .quantStrobe(quantStrobe), .busy(busy), .convDone(convDone), .irq(irq));
  acs_mod_model u_acs_mod_model (.clk(clk), .level(level), .modBit(modBit));
  always #12.5 clk = ~clk;
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (fsTick)
    begin
      nTick <= nTick + 1;
      if (!modReset)
        tickGap <= cyc - lastTick;
      lastTick <= cyc;
    end
    nChop <= nChop + ((chopPolarity && !chopQ) ? 1 : 0);
    nBg <= nBg + ((bandgapState !== bgQ) ? 1 : 0);
    busyCyc <= busyCyc + (busy ? 1 : 0);
    chopQ <= chopPolarity;
    bgQ <= bandgapState;
    if (cyc == 20000)
    begin
      n_errors = n_errors + 1;
      report_and_stop;
    end
  end
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      compares = compares + 1;
      if (g !== e)
      begin
        n_errors = n_errors + 1;
        $display("BAD %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge clk);
      regAddr <= a;
      regWdata <= v;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [31:0] q);
    begin
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      q = regRdata;
    end
  endtask
  task waitDone(input integer lim);
    integer k;
    begin
      k = 0;
      while (convDone !== 1'b1 && k < lim)
      begin
        @(posedge clk);
        #1;
        k = k + 1;
      end
      chk("done", 1, convDone);
    end
  endtask
  task conv(input [6:0] cfg, input integer ticks, input integer rises, input [15:0] res);
    integer t0, c0, b0, dv;
    begin
      dv = (HZ / 62500) >> cfg[1:0];
      wr(8'h04, {25'h0, cfg});
      t0 = nTick;
      c0 = nChop;
      b0 = busyCyc;
      wr(8'h00, 32'h1);
      waitDone(5000);
      @(posedge clk);
      #1;
      chk("ticks", ticks, nTick - t0);
      chk("chop rises", rises, nChop - c0);
      chk("tick gap", dv, tickGap);
      chk("busy span", 1, busyCyc - b0 >= ticks * dv && busyCyc - b0 <= ticks * dv + 16);
      rd(8'h10, d);
      chk("result", res, d[15:0]);
    end
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rd(8'h04, d);
    chk("cfg reset", 32'h2B, d);
    rd(8'h0C, d);
    chk("status reset", 32'h0, d);
    wr(8'h1C, 32'hFFFF);
    rd(8'h1C, d);
    chk("unmapped", 32'h0, d);
    $display("test registers done");
    for (i = 0; i < 5; i = i + 1)
    begin
      wr(8'h08, {17'h0, OC[i*7 +: 7], 1'b0, GC[i*7 +: 7]});
      repeat (3) @(posedge clk);
      #1;
      chk("gain", {25'h0, GC[i*7 +: 7]}, {25'h0, stage3GainNum});
      chk("offset", {25'h0, OE[i*7 +: 7]}, {25'h0, stage3OffsetNum});
    end
    $display("test stage3 done");
    for (i = 0; i < 4; i = i + 1)
      conv(i[6:0], 10, 1, 16'h7FFF);
    conv(7'h43, 37, 2, 16'h0000);
    conv(7'h67, 137, 4, 16'h0000);
    $display("test conversions done");
    wr(8'h14, 32'h3);
    wr(8'h18, 32'h3);
    wr(8'h00, 32'h1);
    wr(8'h00, 32'h1);
    rd(8'h14, d);
    chk("start ignored", 32'h2, d);
    chk("irq on", 1, irq);
    wr(8'h18, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    chk("irq masked", 0, irq);
    waitDone(3000);
    repeat (2) @(posedge clk);
    #1;
    chk("irq done", 1, irq);
    wr(8'h14, 32'h3);
    repeat (2) @(posedge clk);
    #1;
    chk("irq cleared", 0, irq);
    rd(8'h14, d);
    chk("status cleared", 32'h0, d);
    $display("test interrupts done");
    wr(8'h04, 32'h7C);
    wr(8'h00, 32'h1);
    repeat (20) @(posedge clk);
    wr(8'h00, 32'h2);
    rd(8'h04, d);
    chk("cfg restored", 32'h2B, d);
    rd(8'h18, d);
    chk("mask restored", 32'h0, d);
    rd(8'h0C, d);
    chk("busy after restore", 32'h1, d);
    waitDone(600);
    $display("test restore done");
    wr(8'h00, 32'h5);
    waitDone(1000);
    repeat (2) @(posedge clk);
    #1;
    chk("rerun busy", 1, busy);
    wr(8'h00, 32'h0);
    waitDone(1000);
    rd(8'h10, d);
    chk("rerun result", 16'h0000, d[15:0]);
    $display("test free running done");
    wr(8'h04, 32'h43);
    for (i = 0; i < 4; i = i + 1)
    begin
      t = nBg;
      wr(8'h00, {27'h0, i[1:0], 3'b001});
      repeat (40) @(posedge clk);
      #1;
      if (i < 2)
        chk("bg level", (i == 0), bandgapState);
      waitDone(1000);
      @(posedge clk);
      #1;
      tg[i] = nBg - t;
    end
    chk("bg toggles", 1, tg[0] == 0 && tg[3] > 0 && tg[3] < tg[2]);
    $display("test bandgap done");
    report_and_stop;
  end
endmodule

// >>> acs_fs_div.v
`timescale 1ns/100ps
`include "acs_map.vh"

// Oversampling clock enable from the system clock
module acs_fs_div #(
  parameter integer CLK_HZ = 40000000
)(
  input wire clk,
  input wire srst,
  input wire restart,
  input wire [1:0] rateSel,
  output reg tick
);

  localparam integer D0 = CLK_HZ / `ACS_FS_MIN_HZ;
  localparam integer D1 = CLK_HZ / (`ACS_FS_MIN_HZ * 2);
  localparam integer D2 = CLK_HZ / (`ACS_FS_MIN_HZ * 4);
  localparam integer D3 = CLK_HZ / (`ACS_FS_MIN_HZ * 8);
  localparam integer L0 = D0 - 1;
  localparam integer L1 = D1 - 1;
  localparam integer L2 = D2 - 1;
  localparam integer L3 = D3 - 1;

  function [15:0] reloadFor;
    input [1:0] s;
    begin
      case (s)
        2'h0: reloadFor = L0[15:0];
        2'h1: reloadFor = L1[15:0];
        2'h2: reloadFor = L2[15:0];
        default: reloadFor = L3[15:0];
      endcase
    end
  endfunction

  reg [15:0] cnt_q;

  always @(posedge clk)
  begin
    if (srst || restart)
    begin
      cnt_q <= reloadFor(rateSel);
      tick <= 1'b0;
    end
    else if (cnt_q == 16'h0000)
    begin
      cnt_q <= reloadFor(rateSel);
      tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q - 16'h0001;
      tick <= 1'b0;
    end
  end

endmodule

// >>> acs_map.vh
`ifndef ACS_MAP_VH
`define ACS_MAP_VH

// Register offsets (byte addresses)
`define ACS_REG_CTRL 8'h00
`define ACS_REG_CFG 8'h04
`define ACS_REG_STAGE3 8'h08
`define ACS_REG_STATUS 8'h0C
`define ACS_REG_RESULT 8'h10
`define ACS_REG_IRQ_STAT 8'h14
`define ACS_REG_IRQ_MASK 8'h18

// Control register fields
`define ACS_CTRL_START 0
`define ACS_CTRL_DEFAULTS 1
`define ACS_CTRL_CONT 2
`define ACS_CTRL_BG_LO 3
`define ACS_CTRL_BG_HI 4

// Configuration register fields
`define ACS_CFG_FS_LO 0
`define ACS_CFG_FS_HI 1
`define ACS_CFG_OSR_LO 2
`define ACS_CFG_OSR_HI 4
`define ACS_CFG_NEL_LO 5
`define ACS_CFG_NEL_HI 6

// Third stage register fields
`define ACS_S3_GAIN_LO 0
`define ACS_S3_GAIN_HI 6
`define ACS_S3_OFS_LO 8
`define ACS_S3_OFS_HI 14
`define ACS_S3_OFS_SIGN 14

// Interrupt bits
`define ACS_IRQ_DONE 0
`define ACS_IRQ_IGNORED 1
`define ACS_IRQ_W 2

// Defaults: max speed, 2 elementary conversions, ratio of 32
`define ACS_DEF_FS 2'h3
`define ACS_DEF_OSR 3'h2
`define ACS_DEF_NEL 2'h1
`define ACS_DEF_GAIN 7'h00
`define ACS_DEF_OFS 7'h00
`define ACS_DEF_BG 2'h0

// Bandgap modes
`define ACS_BG_HIGH 2'h0
`define ACS_BG_LOW 2'h1
`define ACS_BG_TOG1 2'h2
`define ACS_BG_TOG2 2'h3

// Timing
`define ACS_FS_MIN_HZ 62500
`define ACS_OSR_BASE_LOG2 3
`define ACS_SETUP_CYC 4'h3
`define ACS_CLOSE_CYC 4'h3
`define ACS_RESULT_MSB_LOG2 15

`endif

// >>> acs_mod_model.sv
`timescale 1ns/100ps
module acs_mod_model (
  input wire clk,
  input wire level,
  output reg modBit
);
  // Modulator saturated at one input level
  initial modBit = 1'b0;
  always @(posedge clk)
    modBit <= level;
endmodule
